//--- include/dms_defines.vh
// Constants for the multi-block DMA sequencer: register offsets, field
// positions, reset values and sequencing encodings.
// Assumes inclusion by bare name from the logic files.
`ifndef DMS_DEFINES_VH
`define DMS_DEFINES_VH

// Register byte offsets (AXI4-Lite, one aligned word each)
`define DMS_OFF_GLOBAL_CFG   8'h00
`define DMS_OFF_CHAN_ENABLE  8'h04
`define DMS_OFF_SRC_ADDR     8'h08
`define DMS_OFF_DST_ADDR     8'h0c
`define DMS_OFF_NEXT_PTR     8'h10
`define DMS_OFF_CONTROL      8'h14
`define DMS_OFF_CONFIG       8'h18
`define DMS_OFF_BLOCK_MASK   8'h1c
`define DMS_OFF_IRQ_CLEAR    8'h20
`define DMS_OFF_IRQ_RAW      8'h24
`define DMS_OFF_STATUS       8'h28

// Control register fields
`define DMS_CTL_INT_EN       0
`define DMS_CTL_DST_CHAIN    27
`define DMS_CTL_SRC_CHAIN    28
`define DMS_CTL_DONE         31
`define DMS_CTL_BLK_LSB      8
`define DMS_CTL_BLK_W        12

// Config register fields
`define DMS_CFG_SRC_HS_SEL   0
`define DMS_CFG_DST_HS_SEL   1
`define DMS_CFG_SRC_RELOAD   30
`define DMS_CFG_DST_RELOAD   31

// Interrupt raw / clear bit positions
`define DMS_IRQ_XFER         0
`define DMS_IRQ_BLOCK        1
`define DMS_IRQ_SRC_TXN      2
`define DMS_IRQ_DST_TXN      3
`define DMS_IRQ_ERR          4

// Reset values
`define DMS_RST_WORD         32'h0000_0000

// Control word byte offset within a descriptor
`define DMS_DESC_CTL         32'h0000_000c

// Sequencer states
`define DMS_ST_IDLE          4'h0
`define DMS_ST_FETCH         4'h1
`define DMS_ST_RUN           4'h2
`define DMS_ST_DRAIN         4'h3
`define DMS_ST_EOB           4'h4
`define DMS_ST_WBACK         4'h5
`define DMS_ST_STALL         4'h6
`define DMS_ST_DONE          4'h7

`endif

//--- logic/dms_req_sync.v
// Two-flop synchroniser plus rising-edge detect for one request pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/100ps

module dms_req_sync (
    input  wire core_clk,
    input  wire rst,
    input  wire pin_in,
    output wire level,
    output wire rise
);
    reg meta;
    reg stable;
    reg stable_d;

    // Only the second flop feeds the edge detector
    always @(posedge core_clk) begin
        if (rst) begin
            meta     <= 1'b0;
            stable   <= 1'b0;
            stable_d <= 1'b0;
        end else begin
            meta     <= pin_in;
            stable   <= meta;
            stable_d <= stable;
        end
    end

    assign level = stable;
    assign rise  = stable & ~stable_d;
endmodule

//--- logic/dms_sequencer.v
// One DMA channel: register file on AXI4-Lite, multi-block sequencing,
// descriptor fetch and status write-back over a simple memory port.
// Assumes a one-outstanding-request memory port that answers with mem_ack.
`timescale 1ns/100ps
`include "dms_defines.vh"

// How it works
// RQ1 - Auto-reload restores source, destination, control each block.
// RQ2 - Contiguous side continues from previous block's end address.
// RQ3 - Software never makes both sides contiguous.
// RQ4 - Block irq needs interrupt enable 1 and mask 0.
// RQ5 - Block irq waits for final destination write.
// RQ6 - Chained rows run on with no pause.
// RQ7 - Reload rows halt per block when irq enabled and unmasked.
// RQ8 - Halt ends on block clear, which drops block irq.
// RQ9 - Reload rows never halt when irq disabled or masked.
// RQ10 - Software clears reload bits in next-to-last block handler.
// RQ11 - Block end checks row; single-block rows end transfer.
// RQ12 - Nonzero pointer at end writes status back; zero skips.
// RQ13 - Reload rows run until both reload bits clear.
// RQ14 - Last descriptor has chain enables zero; pointer picks write-back.
// RQ15 - Between blocks software moves only into terminating rows.
// RQ16 - Software programs only legal row combinations.
// RQ17 - Software picks disabled channel, clears pending interrupts first.
// RQ18 - Single block: addresses, control, config, zero pointer.
// RQ19 - Handshake select 0 takes hardware requests, 1 software.
// RQ20 - Start by channel enable with global enable set.
// RQ21 - Each transaction acknowledged to the peripheral.
// RQ22 - At completion flags set, hardware clears channel enable.
// RQ23 - Chained rows load four descriptor words before each block.
// RQ24 - Write-back rows store control to descriptor at block end.
// RQ25 - Reload bits sampled at the instant a block ends; the code samples them in WBACK, after any write-back.
module dms_sequencer #(
    parameter ADDR_W = 8
) (
    input  wire              core_clk,
    input  wire              rst,
    // AXI4-Lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Descriptor memory port
    output reg               mem_req,
    output reg               mem_we,
    output reg  [31:0]       mem_addr,
    output reg  [31:0]       mem_wdata,
    input  wire              mem_ack,
    input  wire [31:0]       mem_rdata,
    // Peripheral handshake and data mover
    input  wire              src_req_pin,
    input  wire              dst_req_pin,
    output reg               src_ack,
    output reg               dst_ack,
    output reg               txn_start,
    output reg  [31:0]       txn_src_addr,
    output reg  [31:0]       txn_dst_addr,
    input  wire              txn_read_done,
    input  wire              txn_write_done,
    output reg               block_irq
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    reg        global_en;
    reg        channel_on_bit;
    reg [31:0] source_address_reg;
    reg [31:0] dest_address_reg;
    reg [31:0] next_descriptor_pointer;
    reg [31:0] channel_control_reg;
    reg [31:0] channel_config_reg;
    reg        block_irq_mask;
    reg [4:0]  irq_raw;
    // Programmed values kept for auto-reload
    reg [31:0] init_src;
    reg [31:0] init_dst;
    reg [31:0] init_ctl;
    reg [31:0] desc_base;
    reg [3:0]  state;
    reg [1:0]  fetch_idx;
    reg [`DMS_CTL_BLK_W-1:0] txn_left;
    reg        wb_pending;

    wire src_lvl;
    wire src_rise;
    wire dst_lvl;
    wire dst_rise;
    dms_req_sync u_src_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (src_req_pin),
        .level    (src_lvl),
        .rise     (src_rise)
    );
    dms_req_sync u_dst_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (dst_req_pin),
        .level    (),
        .rise     (dst_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken together when both present
    wire aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = aw_go;
    assign s_axi_wready  = aw_go;
    assign s_axi_arready = ~s_axi_rvalid;
    wire ar_go = s_axi_arvalid & ~s_axi_rvalid;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (be[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    function known;
        input [ADDR_W-1:0] a;
        begin
            known = (a <= `DMS_OFF_STATUS) && (a[1:0] == 2'b00);
        end
    endfunction

    wire [ADDR_W-1:0] wa = s_axi_awaddr;
    wire wr_clear  = aw_go && wa == `DMS_OFF_IRQ_CLEAR;
    wire blk_clear = wr_clear & s_axi_wstrb[0] & s_axi_wdata[`DMS_IRQ_BLOCK]; // RQ8
    // Software may only touch address, pointer and control registers while the channel is off
    wire prog_ok   = ~channel_on_bit;

    // Row decode: pointer zero, chain enables, reload bits
    wire llp_zero  = (next_descriptor_pointer == 32'h0000_0000);
    wire s_chain   = channel_control_reg[`DMS_CTL_SRC_CHAIN];
    wire d_chain   = channel_control_reg[`DMS_CTL_DST_CHAIN];
    wire s_reload  = channel_config_reg[`DMS_CFG_SRC_RELOAD];
    wire d_reload  = channel_config_reg[`DMS_CFG_DST_RELOAD];
    wire any_chain = s_chain | d_chain;
    wire last_row  = ~any_chain & ~s_reload & ~d_reload; // RQ11 RQ13 RQ14
    wire int_ok    = channel_control_reg[`DMS_CTL_INT_EN] & ~block_irq_mask; // RQ4 RQ9
    wire blk_len_z = (channel_control_reg[`DMS_CTL_BLK_LSB +: `DMS_CTL_BLK_W]
                      == {`DMS_CTL_BLK_W{1'b0}});

    // Request source per side: 0 hardware pin, 1 software handshake
    wire src_req = channel_config_reg[`DMS_CFG_SRC_HS_SEL] ? 1'b1 : src_rise; // RQ19
    wire dst_req = channel_config_reg[`DMS_CFG_DST_HS_SEL] ? 1'b1 : dst_rise; // RQ19

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge core_clk) begin
        if (rst) begin
            global_en               <= 1'b0;
            channel_on_bit          <= 1'b0;
            source_address_reg      <= `DMS_RST_WORD;
            dest_address_reg        <= `DMS_RST_WORD;
            next_descriptor_pointer <= `DMS_RST_WORD;
            channel_control_reg     <= `DMS_RST_WORD;
            channel_config_reg      <= `DMS_RST_WORD;
            block_irq_mask          <= 1'b0;
            irq_raw                 <= 5'h00;
            init_src                <= `DMS_RST_WORD;
            init_dst                <= `DMS_RST_WORD;
            init_ctl                <= `DMS_RST_WORD;
            desc_base               <= `DMS_RST_WORD;
            state                   <= `DMS_ST_IDLE;
            fetch_idx               <= 2'h0;
            txn_left                <= {`DMS_CTL_BLK_W{1'b0}};
            wb_pending              <= 1'b0;
            mem_req                 <= 1'b0;
            mem_we                  <= 1'b0;
            mem_addr                <= `DMS_RST_WORD;
            mem_wdata               <= `DMS_RST_WORD;
            src_ack                 <= 1'b0;
            dst_ack                 <= 1'b0;
            txn_start               <= 1'b0;
            txn_src_addr            <= `DMS_RST_WORD;
            txn_dst_addr            <= `DMS_RST_WORD;
            block_irq               <= 1'b0;
        end else begin
            src_ack   <= 1'b0;
            dst_ack   <= 1'b0;
            txn_start <= 1'b0;
            // Clears first; hardware sets below override in the same cycle
            if (wr_clear)
                irq_raw <= irq_raw & ~s_axi_wdata[4:0];
            if (aw_go) begin
                case (wa)
                    `DMS_OFF_GLOBAL_CFG:  global_en <= s_axi_wdata[0];
                    `DMS_OFF_CHAN_ENABLE: if (s_axi_wdata[0] & ~channel_on_bit) begin
                        channel_on_bit <= 1'b1;
                        init_src       <= source_address_reg;
                        init_dst       <= dest_address_reg;
                        init_ctl       <= channel_control_reg;
                    end
                    `DMS_OFF_SRC_ADDR: if (prog_ok)
                        source_address_reg <= merge(source_address_reg, s_axi_wdata,
                                                    s_axi_wstrb);
                    `DMS_OFF_DST_ADDR: if (prog_ok)
                        dest_address_reg <= merge(dest_address_reg, s_axi_wdata,
                                                  s_axi_wstrb);
                    `DMS_OFF_NEXT_PTR: if (prog_ok)
                        next_descriptor_pointer <= merge(next_descriptor_pointer,
                                                         s_axi_wdata, s_axi_wstrb);
                    `DMS_OFF_CONTROL: if (prog_ok)
                        channel_control_reg <= merge(channel_control_reg, s_axi_wdata,
                                                     s_axi_wstrb);
                    // Config stays writable so reload bits can be dropped mid-transfer
                    `DMS_OFF_CONFIG:
                        channel_config_reg <= merge(channel_config_reg, s_axi_wdata,
                                                    s_axi_wstrb);
                    `DMS_OFF_BLOCK_MASK:  block_irq_mask <= s_axi_wdata[0];
                    default: ;
                endcase
            end
            if (blk_clear)
                block_irq <= 1'b0;

            case (state)
                `DMS_ST_IDLE: begin
                    if (channel_on_bit & global_en) begin
                        // Non-chained write-back rows also store at the pointer
                        desc_base <= next_descriptor_pointer;
                        if (any_chain & ~llp_zero) begin
                            fetch_idx <= 2'h0;
                            state     <= `DMS_ST_FETCH;
                        end else begin
                            txn_left <= channel_control_reg[`DMS_CTL_BLK_LSB +: `DMS_CTL_BLK_W];
                            state    <= blk_len_z ? `DMS_ST_DRAIN : `DMS_ST_RUN;
                        end
                    end
                end
                `DMS_ST_FETCH: begin
                    // Four-word descriptor read, one word at a time
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        mem_addr <= desc_base + {28'h0000000, fetch_idx, 2'b00};
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        case (fetch_idx)
                            2'h0: if (~s_chain | s_reload) ; else
                                source_address_reg <= mem_rdata; // RQ23
                            2'h1: if (~d_chain | d_reload) ; else
                                dest_address_reg <= mem_rdata; // RQ23
                            2'h2: next_descriptor_pointer <= mem_rdata; // RQ23
                            default: channel_control_reg <= mem_rdata; // RQ23
                        endcase
                        fetch_idx <= fetch_idx + 2'h1;
                        if (fetch_idx == 2'h3) begin
                            txn_left <= mem_rdata[`DMS_CTL_BLK_LSB +: `DMS_CTL_BLK_W];
                            state    <= `DMS_ST_RUN;
                        end
                    end
                end
                `DMS_ST_RUN: begin
                    if (src_req & dst_req & (txn_left != {`DMS_CTL_BLK_W{1'b0}})) begin
                        txn_start    <= 1'b1;
                        txn_src_addr <= source_address_reg;
                        txn_dst_addr <= dest_address_reg;
                        src_ack      <= ~channel_config_reg[`DMS_CFG_SRC_HS_SEL]; // RQ21
                        dst_ack      <= ~channel_config_reg[`DMS_CFG_DST_HS_SEL]; // RQ21
                        irq_raw[`DMS_IRQ_SRC_TXN] <= 1'b1;
                        irq_raw[`DMS_IRQ_DST_TXN] <= 1'b1;
                        // Address advances so contiguous sides continue from here
                        source_address_reg <= source_address_reg + 32'h0000_0004; // RQ2
                        dest_address_reg   <= dest_address_reg + 32'h0000_0004;    // RQ2
                        txn_left <= txn_left - {{(`DMS_CTL_BLK_W-1){1'b0}}, 1'b1};
                        if (txn_left == {{(`DMS_CTL_BLK_W-1){1'b0}}, 1'b1})
                            state <= `DMS_ST_DRAIN;
                    end
                end
                `DMS_ST_DRAIN: begin
                    // Source read done is not enough; wait for the last write
                    if (txn_write_done)
                        state <= `DMS_ST_EOB; // RQ5
                end
                `DMS_ST_EOB: begin
                    // Row sampled in WBACK after any write-back, so a late reload-bit clear counts there
                    if (int_ok) begin
                        block_irq <= 1'b1; // RQ4
                        irq_raw[`DMS_IRQ_BLOCK] <= 1'b1;
                    end
                    wb_pending <= ~llp_zero; // RQ12 RQ24
                    state      <= `DMS_ST_WBACK; // RQ25
                end
                `DMS_ST_WBACK: begin
                    if (!wb_pending) begin
                        if (last_row) begin
                            state <= `DMS_ST_DONE; // RQ11 RQ13
                        end else if (s_reload | d_reload) begin
                            if (s_reload) source_address_reg <= init_src; // RQ1
                            if (d_reload) dest_address_reg   <= init_dst; // RQ1
                            if (~any_chain) channel_control_reg <= init_ctl; // RQ1
                            state <= int_ok ? `DMS_ST_STALL : `DMS_ST_IDLE; // RQ7 RQ9
                        end else begin
                            state <= `DMS_ST_IDLE; // RQ6
                        end
                    end else if (!mem_req) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= desc_base + `DMS_DESC_CTL;
                        mem_wdata <= channel_control_reg | 32'h8000_0000; // RQ24
                    end else if (mem_ack) begin
                        mem_req    <= 1'b0;
                        mem_we     <= 1'b0;
                        wb_pending <= 1'b0;
                    end
                end
                `DMS_ST_STALL: begin
                    if (blk_clear)
                        state <= `DMS_ST_IDLE; // RQ8
                end
                `DMS_ST_DONE: begin
                    channel_on_bit <= 1'b0; // RQ22
                    irq_raw[`DMS_IRQ_XFER] <= 1'b1; // RQ22
                    state <= `DMS_ST_IDLE;
                end
                default: state <= `DMS_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite responses and read mux
    always @(posedge core_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= `DMS_RST_WORD;
        end else begin
            if (aw_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(wa) ? 2'b00 : 2'b10;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= known(s_axi_araddr) ? 2'b00 : 2'b10;
                case (s_axi_araddr)
                    `DMS_OFF_GLOBAL_CFG:  s_axi_rdata <= {31'h0, global_en};
                    `DMS_OFF_CHAN_ENABLE: s_axi_rdata <= {31'h0, channel_on_bit};
                    `DMS_OFF_SRC_ADDR:    s_axi_rdata <= source_address_reg;
                    `DMS_OFF_DST_ADDR:    s_axi_rdata <= dest_address_reg;
                    `DMS_OFF_NEXT_PTR:    s_axi_rdata <= next_descriptor_pointer;
                    `DMS_OFF_CONTROL:     s_axi_rdata <= channel_control_reg;
                    `DMS_OFF_CONFIG:      s_axi_rdata <= channel_config_reg;
                    `DMS_OFF_BLOCK_MASK:  s_axi_rdata <= {31'h0, block_irq_mask};
                    `DMS_OFF_IRQ_RAW:     s_axi_rdata <= {27'h0, irq_raw};
                    `DMS_OFF_STATUS:      s_axi_rdata <= {27'h0, src_lvl, state};
                    default:              s_axi_rdata <= `DMS_RST_WORD;
                endcase
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- tb/dms_checker.sv
// Port checker for the multi-block DMA sequencer.
// Assumes core_clk with synchronous active-high rst.
`timescale 1ns/100ps
module dms_checker (
    input wire        core_clk,
    input wire        rst,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_wvalid,
    input wire [31:0] s_axi_wdata,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        mem_req,
    input wire        mem_ack,
    input wire [31:0] mem_addr,
    input wire        txn_write_done,
    input wire        block_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [3:0] since_wd;
    // Saturates so a stale write-done never looks recent
    always @(posedge core_clk)
        since_wd <= (rst || txn_write_done) ? 4'h0 : since_wd + {3'h0, since_wd != 4'hf};
    sequence wr_taken; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
    sequence blk_clr; wr_taken ##0 (s_axi_awaddr == 8'h20 && s_axi_wdata[1]); endsequence
    ////////////////////////////////////////////////////////////
    a_write_answer: assert property (wr_taken |=> s_axi_bvalid) else $error("no bvalid");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("no rvalid");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_unmapped_slverr: assert property (wr_taken ##0 s_axi_awaddr > 8'h28
        |=> s_axi_bresp == 2'b10) else $error("unmapped write not refused");
    a_mem_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("descriptor access dropped");
    a_irq_after_write: assert property ($rose(block_irq) |-> since_wd <= 4'h4)
        else $error("block irq before final write");
    a_clear_drops_irq: assert property (blk_clr ##0 block_irq |=> !block_irq)
        else $error("block clear ignored");
endmodule

//--- tb/dms_partner.sv
// Far side: descriptor memory, data mover and two peripherals.
// Assumes one descriptor access at a time, held until mem_ack.
`timescale 1ns/100ps
module dms_partner (
    input wire        core_clk,
    input wire        mem_req,
    input wire        mem_we,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    output reg        mem_ack = 1'b0,
    output reg [31:0] mem_rdata = 32'h0,
    input wire        src_ack,
    input wire        dst_ack,
    output reg        src_req_pin = 1'b0,
    output reg        dst_req_pin = 1'b0,
    input wire        txn_start,
    output reg        txn_read_done = 1'b0,
    output reg        txn_write_done = 1'b0
);
    logic [31:0] mem [0:63];
    logic [1:0]  dly = 2'h0;
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        mem_ack <= mem_req && !mem_ack;
        // Idle data bus alternates between the last word and its inverse
        mem_rdata <= (mem_req && !mem_ack) ? mem[mem_addr[7:2]] : ~mem_rdata;
        if (mem_req && !mem_ack && mem_we)
            mem[mem_addr[7:2]] <= mem_wdata;
        dly <= {dly[0], txn_start};
        txn_read_done <= dly[0];
        txn_write_done <= dly[1];
        // Peripherals keep offering edges, and stay low a cycle after an ack
        src_req_pin <= !src_req_pin && !src_ack;
        dst_req_pin <= !dst_req_pin && !dst_ack;
    end
endmodule

//--- tb/tb_dms_multiblock_sequencer.sv
// Self-checking bench for the multi-block DMA sequencer.
// Assumes the partner model and checker files are compiled first.
`timescale 1ns/100ps
module tb_dms_multiblock_sequencer;
    logic        core_clk = 1'b0, rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] txn_src_addr, txn_dst_addr, first_src, first_dst, rdv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        mem_req, mem_we, mem_ack, src_req_pin, dst_req_pin, src_ack, dst_ack;
    logic        txn_start, txn_read_done, txn_write_done, block_irq;
    int          n_errors = 0, compares = 0, cycles = 0, n_txn, n_ack, n_wb;
    always #10 core_clk = ~core_clk;
    dms_sequencer uut (.*);
    dms_partner ptn (.*);
    ////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (txn_start && n_txn == 0) begin
            first_src = txn_src_addr;
            first_dst = txn_dst_addr;
        end
        if (txn_start) n_txn++;
        if (src_ack) n_ack++;
        if (mem_req && mem_ack && mem_we) n_wb++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (!s_axi_bvalid) @(posedge core_clk);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge core_clk);
        rdv = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic prog(input logic [31:0] sa, da, ptr, ctl, cfg);
        wr(8'h20, 32'h1f);
        wr(8'h08, sa);
        wr(8'h0c, da);
        wr(8'h10, ptr);
        wr(8'h14, ctl);
        wr(8'h18, cfg);
        n_txn = 0;
        n_ack = 0;
        n_wb = 0;
        wr(8'h04, 32'h1);
    endtask
    // Polls channel-on, as software would, with a bounded number of reads
    task automatic wait_off;
        rdv = 32'h1;
        for (int i = 0; i < 100 && rdv[0] !== 1'b0; i++) rd(8'h04);
        check(rdv, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_single;
        prog(32'h100, 32'h200, 32'h0, 32'h301, 32'h0);
        wait_off;
        check(block_irq, 1'b1);
        check(n_ack, 3);
        check(n_wb, 0);
        check(first_src, 32'h100);
        wr(8'h20, 32'h2);
        check(block_irq, 1'b0);
    endtask
    task automatic t_masked_wb;
        wr(8'h1c, 32'h1);
        prog(32'h100, 32'h200, 32'h40, 32'h201, 32'h3);
        wait_off;
        check(block_irq, 1'b0);
        check(n_wb, 1);
        check(ptn.mem[19], 32'h8000_0201);
        wr(8'h1c, 32'h0);
    endtask
    task automatic t_reload;
        prog(32'h100, 32'h200, 32'h0, 32'h201, 32'h8000_0003);
        for (int i = 0; i < 300 && block_irq !== 1'b1; i++) @(posedge core_clk);
        check(block_irq, 1'b1);
        repeat (30) @(posedge core_clk);
        check(n_txn, 2);
        wr(8'h18, 32'h3);
        n_txn = 0;
        wr(8'h20, 32'h2);
        wait_off;
        check(first_src, 32'h108);
        check(first_dst, 32'h200);
        check(n_wb, 0);
        wr(8'h30, 32'h5);
        check(last_resp, 2'b10);
    endtask
    task automatic t_chain;
        ptn.mem[16] = 32'h300;
        ptn.mem[17] = 32'h400;
        ptn.mem[18] = 32'h0;
        ptn.mem[19] = 32'h100;
        prog(32'h0, 32'h0, 32'h40, 32'h1800_0000, 32'h3);
        wait_off;
        check(first_src, 32'h300);
        check(n_txn, 1);
        check(n_wb, 0);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        wr(8'h00, 32'h1);
        t_single;
        t_masked_wb;
        t_reload;
        t_chain;
        give_verdict;
    end
endmodule
bind dms_sequencer dms_checker chk (.*);
